// ---- eai_top.sv ----
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module eai_top
  import eai_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // measurement chain
  input wire logic signed [eai_pkg::VAL_W-1:0] meas_value,
  input wire logic signed [eai_pkg::VAL_W-1:0] disp_value,
  input wire eai_pkg::eai_diag_t diag,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // panel
  output eai_pkg::eai_leds_t leds,
  output logic [eai_pkg::CODE_W-1:0] err_code,
  output logic err_show,
  output logic min_out,
  output logic max_out,
  output logic irq
);

  // configuration registers
  logic [2:0] func_q, func_d;
  logic signed [VAL_W-1:0] hi_q, hi_d, lo_q, lo_d;
  logic [DLY_W-1:0] dly_q, dly_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic [31:0] rdata_q, rdata_d;

  // indicator and display state
  eai_leds_t leds_q, leds_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic show_q, show_d;
  logic min_out_q, min_out_d, max_out_q, max_out_d;
  logic min_raw, max_raw, min_alarm, max_alarm;
  logic sys_err, minmax_sel;
  logic [IRQ_W-1:0] events;
  logic [CODE_W-1:0] code_sel;

  // limit compares are raw; delay modules filter short excursions
  assign max_raw = meas_value > hi_q;
  assign min_raw = meas_value < lo_q;

  eai_delay_qual #(.W(DLY_W)) u_max_qual (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cond(max_raw),
    .delay(dly_q),
    .qual(max_alarm)
  );

  eai_delay_qual #(.W(DLY_W)) u_min_qual (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cond(min_raw),
    .delay(dly_q),
    .qual(min_alarm)
  );

  // error classification; codes follow inputs live, so clearing is automatic
  // fixed priority order
  always_comb begin
    code_sel = CODE_NONE;
    if (diag.self_fail) begin
      code_sel = CODE_SYSTEM;
    end else if (diag.sensor_fail) begin
      code_sel = CODE_SENSOR;
    end else if (diag.config_fail) begin
      code_sel = CODE_CONFIG;
    end else if (diag.over_range) begin
      code_sel = CODE_OVER;
    end else if (diag.under_range) begin
      code_sel = CODE_UNDER;
    end else if (diag.calc_fail) begin
      code_sel = CODE_CALC;
    end else if (disp_value > DISP_MAX) begin
      code_sel = CODE_DISP_HI;
    end else if (disp_value < DISP_MIN) begin
      code_sel = CODE_DISP_LO;
    end
  end

  // system alarm covers hardware and sensor faults
  assign sys_err = diag.self_fail | diag.sensor_fail;
  assign minmax_sel = func_q == FUNC_MINMAX_ALARM;

  // indicators, display code and switching outputs
  always_comb begin
    leds_d = '0;
    code_d = code_sel;
    show_d = code_sel != CODE_NONE;
    if (minmax_sel) begin
      if (sys_err) begin
        leds_d = '{alarm: 1'b1, min: 1'b1, max: 1'b1};
      end else begin
        leds_d.alarm = min_alarm | max_alarm;
        leds_d.min = min_alarm;
        leds_d.max = max_alarm;
      end
    end
    min_out_d = ~(min_alarm | (minmax_sel & sys_err));
    max_out_d = ~(max_alarm | (minmax_sel & sys_err));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      leds_q <= '0;
      code_q <= CODE_NONE;
      show_q <= 1'b0;
      min_out_q <= 1'b1;
      max_out_q <= 1'b1;
    end else begin
      leds_q <= leds_d;
      code_q <= code_d;
      show_q <= show_d;
      min_out_q <= min_out_d;
      max_out_q <= max_out_d;
    end
  end

  assign events[IRQ_MIN] = min_alarm;
  assign events[IRQ_MAX] = max_alarm;
  assign events[IRQ_ERR] = code_sel != CODE_NONE;

  // register writes, sticky status and reads; a set beats a same-cycle clear
  always_comb begin
    func_d = func_q;
    hi_d = hi_q;
    lo_d = lo_q;
    dly_d = dly_q;
    irq_en_d = irq_en_q;
    irq_stat_d = irq_stat_q;
    rdata_d = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_FUNC: func_d = reg_wdata[2:0];
        REG_HI_LIM: hi_d = reg_wdata[VAL_W-1:0];
        REG_LO_LIM: lo_d = reg_wdata[VAL_W-1:0];
        REG_DELAY: dly_d = reg_wdata[DLY_W-1:0];
        REG_IRQ_CLR: irq_stat_d = irq_stat_q & ~reg_wdata[IRQ_W-1:0];
        REG_IRQ_EN: irq_en_d = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    irq_stat_d = irq_stat_d | events;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_FUNC: rdata_d = {29'h0, func_q};
        REG_HI_LIM: rdata_d = {16'h0, hi_q};
        REG_LO_LIM: rdata_d = {16'h0, lo_q};
        REG_DELAY: rdata_d = {16'h0, dly_q};
        REG_STATUS: rdata_d = {21'h0, show_q, code_q, leds_q, max_alarm, min_alarm, sys_err};
        REG_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
        REG_IRQ_EN: rdata_d = {29'h0, irq_en_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      func_q <= FUNC_RST;
      hi_q <= HI_RST;
      lo_q <= LO_RST;
      dly_q <= DELAY_RST;
      irq_en_q <= '0;
      irq_stat_q <= '0;
      rdata_q <= '0;
    end else begin
      func_q <= func_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      dly_q <= dly_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      rdata_q <= rdata_d;
    end
  end

  assign leds = leds_q;
  assign err_code = code_q;
  assign err_show = show_q;
  assign min_out = min_out_q;
  assign max_out = max_out_q;
  assign irq = |(irq_stat_q & irq_en_q);
  assign reg_rdata = rdata_q;

endmodule : eai_top

// ---- eai_pkg.sv ----
// Notes on behaviour
// - alarm lights driven only when min/max alarm function is selected
// - minimum alarm lights the alarm and min indicators
// - maximum alarm lights the alarm and max indicators
// - system alarm or error lights all three indicators and shows its code; here only self-diagnostic and sensor faults light them
// - impermissible state replaces the reading with its error code
// - input above measuring range or counter overflow shows code 1
// - input below range, live-zero or counter underflow shows code 2
// - codes 1 and 2 clear by themselves once input is back in range
// - display value above 9999 shows code 3, clears when below again
// - display value below -1999 shows code 4, clears when above again
// - self-diagnostic failure shows code 7
// - broken or shorted sensor shows code 9
// - faulty quantity needed for display value shows code 11
// - inconsistent configuration shows code 12
// - alarm switching outputs are inverted: active while no alarm
// - min/max alarm asserts only after limit exceeded for the delay time
package eai_pkg;

  localparam int VAL_W = 16;
  localparam int DLY_W = 16;
  localparam int CODE_W = 4;

  // display limits in digits
  localparam logic signed [VAL_W-1:0] DISP_MAX = 16'sd9999;
  localparam logic signed [VAL_W-1:0] DISP_MIN = -16'sd1999;

  // error codes as shown on the display
  localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;
  localparam logic [CODE_W-1:0] CODE_OVER = 4'h1;
  localparam logic [CODE_W-1:0] CODE_UNDER = 4'h2;
  localparam logic [CODE_W-1:0] CODE_DISP_HI = 4'h3;
  localparam logic [CODE_W-1:0] CODE_DISP_LO = 4'h4;
  localparam logic [CODE_W-1:0] CODE_SYSTEM = 4'h7;
  localparam logic [CODE_W-1:0] CODE_SENSOR = 4'h9;
  localparam logic [CODE_W-1:0] CODE_CALC = 4'hB;
  localparam logic [CODE_W-1:0] CODE_CONFIG = 4'hC;

  // output function selection
  localparam logic [2:0] FUNC_MINMAX_ALARM = 3'h4;

  // interrupt status bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_MIN = 0;
  localparam int IRQ_MAX = 1;
  localparam int IRQ_ERR = 2;

  // register offsets
  localparam logic [3:0] REG_FUNC = 4'h0;
  localparam logic [3:0] REG_HI_LIM = 4'h1;
  localparam logic [3:0] REG_LO_LIM = 4'h2;
  localparam logic [3:0] REG_DELAY = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_CLR = 4'h6;
  localparam logic [3:0] REG_IRQ_EN = 4'h7;

  // reset values
  localparam logic [2:0] FUNC_RST = 3'h0;
  localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;
  localparam logic [VAL_W-1:0] HI_RST = 16'h0000;
  localparam logic [VAL_W-1:0] LO_RST = 16'h0000;

  // condition flags from measuring chain
  typedef struct packed {
    logic over_range;
    logic under_range;
    logic self_fail;
    logic sensor_fail;
    logic calc_fail;
    logic config_fail;
  } eai_diag_t;

  // panel indicator lights
  typedef struct packed {
    logic alarm;
    logic min;
    logic max;
  } eai_leds_t;

endpackage : eai_pkg

// ---- eai_delay_qual.sv ----
`timescale 1ns/10ps
// qualifies a condition: out goes high at the edge where cond has been held for delay+1 edges
module eai_delay_qual #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // condition
  input wire logic cond,
  input wire logic [W-1:0] delay,
  // result
  output logic qual
);

  logic [W-1:0] cnt_q, cnt_d;
  logic qual_q, qual_d;

  // count while condition holds, restart as soon as it drops
  // delay before alarm
  always_comb begin
    cnt_d = '0;
    qual_d = 1'b0;
    if (cond) begin
      if (cnt_q >= delay) begin
        cnt_d = cnt_q;
        qual_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      qual_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      qual_q <= qual_d;
    end
  end

  assign qual = qual_q;

endmodule : eai_delay_qual

// ---- eai_panel_model.sv ----
`timescale 1ns/10ps
// front panel: the four-digit display latches what it is told to show
module eai_panel_model
  import eai_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // panel drive
  input wire eai_pkg::eai_leds_t leds,
  input wire logic [eai_pkg::CODE_W-1:0] err_code,
  input wire logic err_show,
  // what the operator sees
  output logic [eai_pkg::CODE_W-1:0] shown_code,
  output eai_pkg::eai_leds_t lamps
);
  // blank digits while no code replaces the reading; lamps glow one cycle after the drive
  always_ff @(posedge sys_clk) begin
    shown_code <= err_show ? err_code : 4'h0;
    lamps <= leds;
  end
endmodule : eai_panel_model

// ---- eai_top_asserts.sv ----
`timescale 1ns/10ps
module eai_top_asserts
  import eai_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // watched ports
  input wire eai_pkg::eai_diag_t diag,
  input wire logic signed [eai_pkg::VAL_W-1:0] disp_value,
  input wire eai_pkg::eai_leds_t leds,
  input wire logic [eai_pkg::CODE_W-1:0] err_code,
  input wire logic err_show,
  input wire logic max_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // system faults outrank every other code
  wire sys_f = diag.self_fail | diag.sensor_fail;
  AST_SELF: assert property (diag.self_fail |=> err_code == CODE_SYSTEM)
    else $error("self test code wrong");
  AST_SENSOR: assert property (
    !diag.self_fail && diag.sensor_fail |=> err_code == CODE_SENSOR)
    else $error("sensor code wrong");
  AST_CONFIG: assert property (!sys_f && diag.config_fail |=> err_code == CODE_CONFIG)
    else $error("config code wrong");
  AST_OVER: assert property (
    !sys_f && !diag.config_fail && diag.over_range |=> err_code == CODE_OVER)
    else $error("over range code wrong");
  AST_DISP_HI: assert property (
    diag == 6'h00 && disp_value > DISP_MAX |=> err_show && err_code == CODE_DISP_HI)
    else $error("display high code wrong");
  AST_CLEAR: assert property (
    diag == 6'h00 && disp_value <= DISP_MAX && disp_value >= DISP_MIN
    |=> !err_show && err_code == CODE_NONE)
    else $error("code did not clear");
  AST_MIN_PAIR: assert property (leds.min && !leds.max |-> leds.alarm)
    else $error("min light without alarm light");
  AST_MAX_OUT: assert property (leds.max && !leds.min |-> leds.alarm && !max_out)
    else $error("max alarm output not inverted");
endmodule : eai_top_asserts

bind eai_top eai_top_asserts eai_top_asserts_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .diag(diag),
  .disp_value(disp_value), .leds(leds), .err_code(err_code), .err_show(err_show), .max_out(max_out));

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import eai_pkg::*;
  logic sys_clk, sys_rst, reg_wr, reg_rd, err_show, min_out, max_out, irq;
  logic signed [15:0] meas_value, disp_value;
  eai_diag_t diag;
  eai_leds_t leds, lamps;
  logic [3:0] reg_addr, err_code, shown;
  logic [31:0] reg_wdata, reg_rdata, v;
  int bad_count, cmp_count, n;
  logic [3:0] ctab [6] = '{CODE_OVER, CODE_UNDER, CODE_SYSTEM, CODE_SENSOR, CODE_CALC, CODE_CONFIG};
  eai_top eai_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .meas_value(meas_value),
    .disp_value(disp_value), .diag(diag), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .leds(leds), .err_code(err_code),
    .err_show(err_show), .min_out(min_out), .max_out(max_out), .irq(irq));
  eai_panel_model eai_panel_model_i (.sys_clk(sys_clk), .leds(leds), .err_code(err_code),
    .err_show(err_show), .shown_code(shown), .lamps(lamps));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tick
  // an edge passes with the strobe low, so a following write never re-raises it at once
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr
  // data stand one cycle after the strobe, sampled at the edge closing it
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
    v = reg_rdata;
  endtask : rd
  task automatic t_regs;
    rd(REG_FUNC);
    chk("func reset", 32'h0, v);
    wr(REG_HI_LIM, 32'h64);
    rd(REG_HI_LIM);
    chk("upper limit", 32'h64, v);
    rd(4'hF);
    chk("unmapped", 32'h0, v);
  endtask : t_regs
  // one fault at a time, then overlapping faults for the priority
  task automatic t_codes;
    for (int i = 0; i < 6; i++) begin
      diag <= 6'h20 >> i;
      tick(2);
      chk("code", {28'h0, ctab[i]}, {28'h0, err_code});
      chk("show", 32'h1, {31'h0, err_show});
    end
    diag <= 6'h3F;
    tick(2);
    chk("prio", {28'h0, CODE_SYSTEM}, {28'h0, err_code});
    // configuration outranks range and calculation faults, under range outranks calculation
    diag <= 6'h33;
    tick(2);
    chk("prio cfg", {28'h0, CODE_CONFIG}, {28'h0, err_code});
    diag <= 6'h12;
    tick(2);
    chk("prio under", {28'h0, CODE_UNDER}, {28'h0, err_code});
    diag <= 6'h00;
    tick(2);
    chk("cleared", 32'h0, {31'h0, err_show});
  endtask : t_codes
  // display limits are strict, so the limit values themselves show no code
  task automatic t_disp;
    disp_value <= 16'sd10000;
    tick(2);
    chk("disp hi", {28'h0, CODE_DISP_HI}, {28'h0, err_code});
    disp_value <= 16'sd9999;
    tick(2);
    chk("disp hi edge", 32'h0, {31'h0, err_show});
    disp_value <= -16'sd2000;
    tick(2);
    chk("disp lo", {28'h0, CODE_DISP_LO}, {28'h0, err_code});
    disp_value <= -16'sd1999;
    tick(2);
    chk("disp edge", 32'h0, {31'h0, err_show});
  endtask : t_disp
  task automatic t_alarm;
    wr(REG_FUNC, 32'h4);
    wr(REG_LO_LIM, 32'hFF9C);
    wr(REG_DELAY, 32'h3);
    wr(REG_IRQ_EN, 32'h2);
    meas_value <= 16'sd200;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (max_out !== 1'b0 && n < 40);
    // delay 3: four held edges qualify, one flop more, seen at the edge after
    chk("delay", 32'd6, n);
    chk("max leds", 32'h5, {29'h0, leds});
    chk("irq", 32'h1, {31'h0, irq});
    // status: max alarm, alarm and max lights, no code shown
    rd(REG_STATUS);
    chk("status", 32'h2C, v);
    // the error bit is still set from the code scenarios
    rd(REG_IRQ_STAT);
    chk("irq stat", 32'h6, v);
    meas_value <= -16'sd200;
    tick(8);
    chk("min leds", 32'h6, {29'h0, leds});
    chk("min out", 32'h0, {31'h0, min_out});
    meas_value <= 16'sd0;
    diag <= 6'h08;
    tick(3);
    chk("sys leds", 32'h7, {29'h0, leds});
    chk("sys lamps", 32'h7, {29'h0, lamps});
    chk("sys shown", {28'h0, CODE_SYSTEM}, {28'h0, shown});
    diag <= 6'h00;
    wr(REG_IRQ_EN, 32'h0);
    tick(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_CLR, 32'h7);
    wr(REG_IRQ_EN, 32'h2);
    tick(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(REG_FUNC, 32'h0);
    meas_value <= 16'sd200;
    tick(9);
    chk("leds off", 32'h0, {29'h0, leds});
    chk("out any mode", 32'h0, {31'h0, max_out});
  endtask : t_alarm
  task automatic end_of_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {meas_value, disp_value, diag} = '0;
    sys_rst = 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    t_regs();
    t_codes();
    t_disp();
    t_alarm();
    end_of_test();
  end
endmodule : testbench
